/* File: include/iar_pkg.sv */
package iar_pkg;
  localparam logic [6:0] TGT_ADDR = 7'h37;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned PTR_W = 8;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned FIFO_W = PTR_W + WORD_W;
  localparam int NUM_REGS_DFLT = 40;
  localparam logic [WORD_W-1:0] OOR_WORD = 16'hffff;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [3:0] BIT_ONE = 4'h1;
  localparam logic [PTR_W-1:0] PTR_RST = 8'h00;
  localparam logic [PTR_W-1:0] PTR_MAX = 8'hff;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_DEV     = 4'h1,
    ST_DEV_ACK = 4'h2,
    ST_PTR     = 4'h3,
    ST_PTR_ACK = 4'h4,
    ST_WR      = 4'h5,
    ST_WR_ACK  = 4'h6,
    ST_RD      = 4'h7,
    ST_RD_ACK  = 4'h8
  } iar_state_t;
endpackage

/* File: hdl/iar_fifo.sv */
`timescale 1ns/1ps
module iar_fifo #(
  parameter int unsigned W = 24,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic in_valid, // Write word offered
  output logic in_ready, // Room for a word
  input wire logic [W-1:0] in_data, // Word to store
  output logic out_valid, // Head word present
  input wire logic out_ready, // Sink takes head word
  output logic [W-1:0] out_data // Head word
);
  localparam int unsigned AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1) begin : g_bad
      $error("iar_fifo: DEPTH must be a power of two of at least 2");
    end
  endgenerate

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
  logic [AW:0] cnt_q, cnt_d;
  logic out_valid_q, out_valid_d;
  logic [W-1:0] out_data_q, out_data_d;
  logic push, load;

  // Output stage is a register so the sink sees flop-driven data
  // Output word counts against DEPTH, else the buffer would hold one extra
  always_comb begin
    in_ready = ((cnt_q + (AW+1)'(out_valid_q)) != (AW+1)'(DEPTH));
    push = in_valid & in_ready;
    load = (cnt_q != '0) & (~out_valid_q | out_ready);
    wptr_d = wptr_q + AW'(push);
    rptr_d = rptr_q + AW'(load);
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(load);
    out_valid_d = load | (out_valid_q & ~out_ready);
    out_data_d = load ? mem_q[rptr_q] : out_data_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0;
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end else begin
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      cnt_q <= cnt_d;
      out_valid_q <= out_valid_d;
      out_data_q <= out_data_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wptr_q] <= in_data;
    end
  end

  assign out_valid = out_valid_q;
  assign out_data = out_data_q;
endmodule

/* File: hdl/iar_target.sv */
`timescale 1ns/1ps
module iar_target #(
  parameter int NUM_REGS = iar_pkg::NUM_REGS_DFLT,
  parameter int unsigned DEPTH = iar_pkg::FIFO_DEPTH
) (
  input wire logic clk, // System clock, 10 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic scl_i, // Bus clock pin level
  input wire logic sda_i, // Bus data pin level
  output logic sda_o, // Data pin drive value, always low
  output logic sda_oe, // Pull data pin low when high
  output logic [iar_pkg::PTR_W-1:0] rd_addr, // Register being read
  input wire logic [iar_pkg::WORD_W-1:0] rd_data, // Content of rd_addr
  output logic wr_valid, // Register write pending
  input wire logic wr_ready, // Register file takes the write
  output logic [iar_pkg::PTR_W-1:0] wr_addr, // Register to write
  output logic [iar_pkg::WORD_W-1:0] wr_data // Value to write
);
  import iar_pkg::*;

  generate
    if (NUM_REGS < 1 || NUM_REGS > (1 << PTR_W)) begin : g_bad
      $error("iar_target: NUM_REGS must lie in 1..256");
    end
  endgenerate

  // Pin synchronisers; edges compare the second stage against the third
  logic scl_s1_q, scl_s2_q, scl_p_q;
  logic sda_s1_q, sda_s2_q, sda_p_q;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  always_ff @(posedge clk) begin
    if (rst) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_s1_q <= scl_i;
      scl_s2_q <= scl_s1_q;
      scl_p_q <= scl_s2_q;
      sda_s1_q <= sda_i;
      sda_s2_q <= sda_s1_q;
      sda_p_q <= sda_s2_q;
    end
  end

  always_comb begin
    scl_rise = scl_s2_q & ~scl_p_q;
    scl_fall = ~scl_s2_q & scl_p_q;
    bus_start = scl_s2_q & scl_p_q & sda_p_q & ~sda_s2_q;
    bus_stop = scl_s2_q & scl_p_q & ~sda_p_q & sda_s2_q;
  end

  // Transaction state
  iar_state_t state_q, state_d;
  logic [3:0] bit_q, bit_d;
  logic [BYTE_W-1:0] sh_q, sh_d;
  logic [BYTE_W-1:0] wbuf_q, wbuf_d;
  logic [PTR_W-1:0] ptr_q, ptr_d;
  logic hi_q, hi_d;
  logic ack_q, ack_d;
  logic oe_q, oe_d;
  logic push;
  logic fifo_in_ready;
  logic in_range;
  logic [WORD_W-1:0] rd_word;
  logic [BYTE_W-1:0] rd_byte;

  always_comb begin
    in_range = (32'(ptr_q) < NUM_REGS);
    rd_word = in_range ? rd_data : OOR_WORD;
    rd_byte = hi_q ? rd_word[WORD_W-1:BYTE_W] : rd_word[BYTE_W-1:0];
  end

  always_comb begin
    state_d = state_q;
    bit_d = bit_q;
    sh_d = sh_q;
    wbuf_d = wbuf_q;
    ptr_d = ptr_q;
    hi_d = hi_q;
    ack_d = ack_q;
    oe_d = oe_q;
    push = 1'b0;
    if (bus_start) begin
      state_d = ST_DEV;
      bit_d = BIT_ZERO;
      oe_d = 1'b0;
      hi_d = 1'b1;
    end else if (bus_stop) begin
      state_d = ST_IDLE;
      oe_d = 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
        end
        ST_DEV, ST_PTR, ST_WR: begin
          if (scl_rise && bit_q != BIT_LAST) begin
            sh_d = {sh_q[BYTE_W-2:0], sda_s2_q};
            bit_d = bit_q + BIT_ONE;
          end else if (scl_fall && bit_q == BIT_LAST) begin
            if (state_q == ST_DEV) begin
              ack_d = (sh_q[BYTE_W-1:1] == TGT_ADDR);
              state_d = ST_DEV_ACK;
            end else if (state_q == ST_PTR) begin
              ack_d = (32'(sh_q) < NUM_REGS);
              ptr_d = sh_q;
              hi_d = 1'b1;
              state_d = ST_PTR_ACK;
            end else if (hi_q) begin
              wbuf_d = sh_q;
              ack_d = in_range;
              hi_d = 1'b0;
              state_d = ST_WR_ACK;
            end else begin
              // Full buffer refuses the word so the host sees the back-pressure
              ack_d = in_range & fifo_in_ready;
              push = ack_d;
              hi_d = 1'b1;
              if (ack_d) begin
                ptr_d = PTR_W'(ptr_q + 1'b1);
              end
              state_d = ST_WR_ACK;
            end
            oe_d = ack_d;
          end
        end
        ST_DEV_ACK, ST_PTR_ACK, ST_WR_ACK: begin
          if (scl_fall) begin
            oe_d = 1'b0;
            bit_d = BIT_ZERO;
            if (!ack_q) begin
              state_d = ST_IDLE;
            end else if (state_q == ST_DEV_ACK && sh_q[0]) begin
              // Read starts wherever the pointer stands
              sh_d = rd_byte;
              oe_d = ~rd_byte[BYTE_W-1];
              bit_d = BIT_ONE;
              state_d = ST_RD;
            end else if (state_q == ST_DEV_ACK) begin
              state_d = ST_PTR;
            end else begin
              state_d = ST_WR;
            end
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            if (bit_q == BIT_LAST) begin
              oe_d = 1'b0;
              hi_d = ~hi_q;
              if (!hi_q && ptr_q != PTR_MAX) begin
                ptr_d = PTR_W'(ptr_q + 1'b1);
              end
              state_d = ST_RD_ACK;
            end else begin
              oe_d = ~sh_q[BYTE_W-2];
              sh_d = {sh_q[BYTE_W-2:0], 1'b0};
              bit_d = bit_q + BIT_ONE;
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            ack_d = ~sda_s2_q;
          end else if (scl_fall) begin
            if (ack_q) begin
              sh_d = rd_byte;
              oe_d = ~rd_byte[BYTE_W-1];
              bit_d = BIT_ONE;
              state_d = ST_RD;
            end else begin
              state_d = ST_IDLE;
            end
          end
        end
        default: begin
          state_d = ST_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      bit_q <= BIT_ZERO;
      sh_q <= BYTE_RST;
      wbuf_q <= BYTE_RST;
      ptr_q <= PTR_RST;
      hi_q <= 1'b1;
      ack_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      wbuf_q <= wbuf_d;
      ptr_q <= ptr_d;
      hi_q <= hi_d;
      ack_q <= ack_d;
      oe_q <= oe_d;
    end
  end

  // Open-drain: the level driven is fixed low, only the enable moves
  logic sda_o_q;
  always_ff @(posedge clk) begin
    sda_o_q <= 1'b0;
  end

  logic [FIFO_W-1:0] fifo_out;

  iar_fifo #(
    .W(FIFO_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data({ptr_q, wbuf_q, sh_q}),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(fifo_out)
  );

  assign sda_o = sda_o_q;
  assign sda_oe = oe_q;
  assign rd_addr = ptr_q;
  assign wr_addr = fifo_out[FIFO_W-1:WORD_W];
  assign wr_data = fifo_out[WORD_W-1:0];
endmodule

/* File: dv/iar_target_monitor.sv */
`timescale 1ns/1ps
module iar_target_monitor #(
  parameter int NUM_REGS = iar_pkg::NUM_REGS_DFLT
) (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic scl_i, // Bus clock level
  input wire logic sda_i, // Bus data level
  input wire logic sda_oe, // Target pulls data low
  input wire logic wr_valid, // Write word pending
  input wire logic wr_ready, // Sink takes word
  input wire logic [iar_pkg::PTR_W-1:0] wr_addr, // Word register
  input wire logic [iar_pkg::WORD_W-1:0] wr_data // Word value
);
  import iar_pkg::*;
  logic [3:0] cnt_q;
  logic [1:0] nb_q;
  logic [7:0] sh_q;
  logic scl_q;
  logic wr_q;
  logic hit_q;
  logic slot;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Raw pins; the target lags by its synchroniser, hence the ##2 below
  assign slot = scl_i && !scl_q && cnt_q == 4'h8;
  always_ff @(posedge clk) begin
    scl_q <= rst ? 1'b1 : scl_i;
    if (rst || (scl_i && $fell(sda_i))) begin
      cnt_q <= 4'h0;
      nb_q <= 2'h0;
    end else if (scl_i && !scl_q) begin
      cnt_q <= slot ? 4'h0 : cnt_q + 4'h1;
      sh_q <= slot ? sh_q : {sh_q[6:0], sda_i};
      nb_q <= (slot && nb_q != 2'h3) ? nb_q + 2'h1 : nb_q;
      wr_q <= (slot && nb_q == 2'h0) ? !sh_q[0] : wr_q;
      hit_q <= (slot && nb_q == 2'h0) ? sh_q[7:1] == TGT_ADDR : hit_q;
    end
  end
  property p_ack_own;
    slot && nb_q == 2'h0 && sh_q[7:1] == TGT_ADDR |-> ##2 sda_oe;
  endproperty
  a_ack_own: assert property (p_ack_own) else $error("own address not acked");
  property p_nack_other;
    slot && nb_q == 2'h0 && sh_q[7:1] != TGT_ADDR |-> ##2 !sda_oe;
  endproperty
  a_nack_other: assert property (p_nack_other) else $error("other address acked");
  property p_nack_ptr;
    slot && nb_q == 2'h1 && hit_q && wr_q && sh_q >= NUM_REGS |-> ##2 !sda_oe;
  endproperty
  a_nack_ptr: assert property (p_nack_ptr) else $error("bad register acked");
  property p_ack_ptr;
    slot && nb_q == 2'h1 && hit_q && wr_q && sh_q < NUM_REGS |-> ##2 sda_oe;
  endproperty
  a_ack_ptr: assert property (p_ack_ptr) else $error("good register not acked");
  property p_oe_hold;
    scl_i && !scl_q |-> ##2 $stable(sda_oe)[*2];
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("data moved while clock high");
  property p_start_idle;
    scl_i && $fell(sda_i) |-> ##4 !sda_oe;
  endproperty
  a_start_idle: assert property (p_start_idle) else $error("data held after start");
  property p_wr_hold;
    wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr) && $stable(wr_data);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("stalled word changed");
  property p_wr_range;
    wr_valid |-> wr_addr < NUM_REGS;
  endproperty
  a_wr_range: assert property (p_wr_range) else $error("word outside range");
  c_push: cover property (wr_valid && wr_ready);
  c_stall: cover property (wr_valid && !wr_ready);
  c_bad_ptr: cover property (slot && nb_q == 2'h1 && wr_q && sh_q >= NUM_REGS);
endmodule
bind iar_target iar_target_monitor #(.NUM_REGS(NUM_REGS)) u_mon (.clk(clk), .rst(rst),
  .scl_i(scl_i), .sda_i(sda_i), .sda_oe(sda_oe), .wr_valid(wr_valid), .wr_ready(wr_ready),
  .wr_addr(wr_addr), .wr_data(wr_data));

/* File: dv/iar_host_model.sv */
`timescale 1ns/1ps
module iar_host_model (
  input wire logic clk, // System clock
  input wire logic sda, // Resolved data line
  output logic scl, // Bus clock, still between frames
  output logic sda_oe // Host pulls data low
);
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  task automatic q();
    repeat (2) @(posedge clk);
  endtask
  // Also the repeated start, entered with clock low
  task automatic start();
    sda_oe <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_oe <= 1'b1;
    q();
    scl <= 1'b0;
    q();
  endtask
  task automatic stop();
    sda_oe <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_oe <= 1'b0;
    q();
  endtask
  // Low 4 cycles so the target's late drive settles before the rise
  task automatic bit_io(input logic b, output logic r);
    sda_oe <= !b;
    q();
    scl <= 1'b1;
    q();
    r = sda;
    q();
    scl <= 1'b0;
    q();
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // Nine pulses with data released, then a stop, free a target stuck low
  task automatic bus_clear();
    logic r;
    for (int i = 0; i < 9; i++) bit_io(1'b1, r);
    stop();
  endtask
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!ack, r);
  endtask
endmodule

/* File: dv/test_iar_target.sv */
`timescale 1ns/1ps
module test_iar_target;
  import iar_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr_ready = 1'b0;
  logic [WORD_W-1:0] rd_data = 16'h0000;
  logic scl, h_oe, sda_oe, wr_valid, sda_do;
  logic [PTR_W-1:0] rd_addr, wr_addr;
  logic [WORD_W-1:0] wr_data;
  logic [23:0] got[$];
  int fail_count = 0;
  int compares = 0;
  // Open-drain bus: the target's drive value only counts while enabled
  wire logic sda = (sda_oe ? sda_do : 1'b1) && !h_oe;
  always #50 clk = ~clk;
  function automatic logic [15:0] regv(logic [7:0] a);
    return {a, ~a};
  endfunction
  always @(posedge clk) rd_data <= regv(rd_addr);
  always @(posedge clk) if (wr_valid === 1'b1 && wr_ready === 1'b1) got.push_back({wr_addr, wr_data});
  iar_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_oe(h_oe));
  iar_target dut (.clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_do), .sda_oe(sda_oe),
    .rd_addr(rd_addr), .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_addr(wr_addr), .wr_data(wr_data));
  task automatic chk(string n, logic [23:0] e, logic [23:0] s);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test();
    if (fail_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [7:0] b, input logic e);
    logic a;
    host.wbyte(b, a);
    chk("ack", {23'h0, e}, {23'h0, a});
  endtask
  task automatic rw(input logic [15:0] e, input logic last);
    logic [7:0] d;
    host.rbyte(1'b1, d);
    chk("hi", {16'h0, e[15:8]}, {16'h0, d});
    host.rbyte(!last, d);
    chk("lo", {16'h0, e[7:0]}, {16'h0, d});
  endtask
  task automatic drain();
    for (int n = 0; n < 50 && wr_valid !== 1'b0; n++) @(posedge clk);
  endtask
  // Sink stalls until the stop that follows the buffer refusing the 17th word
  task automatic t_fill();
    wr_ready <= 1'b0;
    host.start();
    wr(8'h6e, 1'b1);
    wr(8'h02, 1'b1);
    for (int i = 0; i < 17; i++) begin
      wr(8'h5a, 1'b1);
      wr(i[7:0], i < 16);
    end
    host.stop();
    wr_ready <= 1'b1;
    drain();
    chk("count", 24'd16, 24'(got.size()));
    for (int i = 0; i < 16; i++) chk("word", {8'h02 + i[7:0], 8'h5a, i[7:0]}, got[i]);
  endtask
  task automatic t_oor();
    got.delete();
    host.start();
    wr(8'h6e, 1'b1);
    wr(8'd39, 1'b1);
    wr(8'h12, 1'b1);
    wr(8'h34, 1'b1);
    wr(8'h56, 1'b0);
    host.stop();
    host.start();
    wr(8'h6e, 1'b1);
    wr(8'd40, 1'b0);
    host.stop();
    host.start();
    wr(8'h70, 1'b0);
    host.stop();
    drain();
    chk("oor_cnt", 24'd1, 24'(got.size()));
    chk("oor_word", {8'd39, 16'h1234}, got[0]);
  endtask
  // Read broken off mid-byte while the target drives a zero
  task automatic t_clear();
    logic r;
    host.start();
    wr(8'h6e, 1'b1);
    wr(8'h00, 1'b1);
    host.start();
    wr(8'h6f, 1'b1);
    repeat (3) host.bit_io(1'b1, r);
    chk("held", 24'd0, {23'h0, sda});
    host.bus_clear();
    chk("clear", 24'd1, {23'h0, sda});
  endtask
  task automatic t_read();
    host.start();
    wr(8'h6e, 1'b1);
    wr(8'd38, 1'b1);
    host.start();
    wr(8'h6f, 1'b1);
    rw(regv(8'd38), 1'b0);
    rw(regv(8'd39), 1'b0);
    rw(16'hffff, 1'b1);
    host.stop();
  endtask
  task automatic t_cur();
    host.start();
    wr(8'h6e, 1'b1);
    wr(8'd5, 1'b1);
    host.stop();
    host.start();
    wr(8'h6f, 1'b1);
    rw(regv(8'd5), 1'b1);
    host.stop();
    chk("idle", 24'd1, {23'h0, sda});
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_fill();
    t_oor();
    t_read();
    t_clear();
    t_cur();
    finish_test();
  end
  initial begin
    repeat (12000) @(posedge clk);
    fail_count++;
    finish_test();
  end
endmodule
